// File: design/edge_sched_pkg.sv
// Constants and types for the output compare channel
package edge_sched_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DELAY = 4'h1;
  localparam logic [3:0] ADDR_REF_TIME = 4'h2;
  localparam logic [3:0] ADDR_RATIO = 4'h3;
  localparam logic [3:0] ADDR_MATCH = 4'h4;
  localparam logic [3:0] ADDR_TB1 = 4'h5;
  localparam logic [3:0] ADDR_TB2 = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_SERVICE = 4'h9;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CTRL_EDGE_LSB = 0;
  localparam int CTRL_SEQ_LSB = 2;
  localparam int CTRL_PRIO_LSB = 4;
  localparam int CTRL_IEN_BIT = 6;
  localparam int CTRL_TBSEL_BIT = 7;

  // ----------------------------------------
  // Reset values and fixed counts
  // ----------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0003;
  localparam logic [1:0] CALC_CYCLES = 2'h2;
  localparam int STAT_SERVICE_BIT = 0;
  localparam int STAT_OVERRUN_BIT = 1;

  // Edge action
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_HIGH = 2'h1,
    EDGE_LOW = 2'h2,
    EDGE_TOGGLE = 2'h3
  } edge_act_t;

  // Service request codes
  typedef enum logic [1:0] {
    SVC_NONE = 2'h0,
    SVC_PULSE = 2'h1,
    SVC_UNUSED = 2'h2,
    SVC_CONT = 2'h3
  } svc_t;

  // Priority codes
  typedef enum logic [1:0] {
    PRIO_OFF = 2'h0,
    PRIO_LOW = 2'h1,
    PRIO_MED = 2'h2,
    PRIO_HIGH = 2'h3
  } prio_t;

  // Channel sequencer, Gray along idle-calc-run and idle-arm
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h2,
    ST_CALC = 2'h1,
    ST_RUN = 2'h3
  } state_t;

endpackage : edge_sched_pkg

// File: design/output_compare_channel.sv
// Output compare channel with host pulse, referenced and continuous modes
`timescale 1ns/1ps
module output_compare_channel
  import edge_sched_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Shared timebases, same clock
  input wire logic [15:0] timebase_one_count,
  input wire logic [15:0] timebase_two_count,
  // Link from another channel and its referenced period
  input wire logic link_in,
  input wire logic [15:0] period_reference_value,
  // Scheduler grant for this channel's service
  input wire logic service_grant,
  // Outputs
  output logic pin_out,
  output logic [1:0] service_prio,
  output logic service_req,
  output logic irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] delay_q;
  logic [15:0] ref_time_q;
  logic [15:0] ratio_q;
  logic [15:0] match_q;
  logic [15:0] offset_q;
  logic [15:0] tb1_cap_q;
  logic [15:0] tb2_cap_q;
  logic [15:0] status_q;
  logic [15:0] mask_q;
  logic [1:0] svc_q;
  logic [1:0] calc_cnt_q;
  state_t state_q;
  logic cont_q;

  edge_act_t edge_act;
  prio_t prio;
  logic seq_sample;
  logic [15:0] now;
  logic matched;
  logic fire;
  logic svc_event;
  logic [31:0] product;
  logic svc_wr;
  logic enabled;

  assign edge_act = edge_act_t'(ctrl_q[CTRL_EDGE_LSB +: 2]);
  assign prio = prio_t'(ctrl_q[CTRL_PRIO_LSB +: 2]);
  assign seq_sample = ctrl_q[CTRL_SEQ_LSB + 1];
  assign enabled = (prio != PRIO_OFF);
  assign now = ctrl_q[CTRL_TBSEL_BIT] ? timebase_two_count : timebase_one_count;
  assign matched = (now == match_q);
  assign svc_wr = reg_wr && (reg_addr == ADDR_SERVICE);
  // Ratio is a 0.16 fraction so offset is period scaled down
  assign product = period_reference_value * ratio_q;

  // ----------------------------------------
  // Host register writes
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RESET;
      delay_q <= 16'h0000;
      ref_time_q <= 16'h0000;
      ratio_q <= 16'h0000;
      mask_q <= MASK_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: ctrl_q <= reg_wdata;
        ADDR_DELAY: delay_q <= reg_wdata;
        ADDR_REF_TIME: ref_time_q <= reg_wdata;
        ADDR_RATIO: ratio_q <= reg_wdata;
        ADDR_MASK: mask_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer: pending service, arming and continuous run
  // ----------------------------------------
  // The host write only latches the code; it runs when this channel is granted,
  // so a disabled channel keeps its request pending but never acts.
  assign fire = (svc_q != SVC_NONE) && service_grant && enabled;
  // The unused code is dropped silently, so it raises no service flag
  assign svc_event = (fire && svc_q != SVC_UNUSED)
                     || ((state_q == ST_ARMED || state_q == ST_RUN) && matched
                         && !seq_sample && enabled);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      svc_q <= SVC_NONE;
    end else if (svc_wr) begin
      svc_q <= reg_wdata[1:0];
    end else if (fire) begin
      svc_q <= SVC_NONE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      match_q <= 16'h0000;
      offset_q <= 16'h0000;
      calc_cnt_q <= 2'h0;
      cont_q <= 1'b0;
    end else if (fire && seq_sample) begin
      state_q <= ST_IDLE;
    end else if (fire && svc_q == SVC_PULSE) begin
      // Edge now, second edge after delay from the reference or from now
      state_q <= ST_ARMED;
      cont_q <= 1'b0;
      match_q <= ((ref_time_q != 16'h0000) ? ref_time_q : now) + delay_q;
    end else if (fire && svc_q == SVC_CONT) begin
      state_q <= ST_IDLE;
      cont_q <= 1'b1;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cont_q && link_in && enabled && !seq_sample) begin
            state_q <= ST_CALC;
            offset_q <= product[31:16];
            calc_cnt_q <= CALC_CYCLES;
          end
        end
        ST_ARMED: begin
          if (matched) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CALC: begin
          if (calc_cnt_q == 2'h1) begin
            state_q <= ST_RUN;
            match_q <= now + offset_q;
          end
          calc_cnt_q <= calc_cnt_q - 2'h1;
        end
        ST_RUN: begin
          if (matched) begin
            match_q <= match_q + offset_q;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 1'b0;
    end else if ((fire && svc_q == SVC_PULSE && !seq_sample) ||
                 (state_q == ST_ARMED && matched)) begin
      unique case (edge_act)
        EDGE_HIGH: pin_out <= 1'b1;
        EDGE_LOW: pin_out <= 1'b0;
        EDGE_TOGGLE: pin_out <= !pin_out;
        EDGE_NONE: pin_out <= pin_out;
      endcase
    end else if (state_q == ST_RUN && matched && enabled) begin
      pin_out <= !pin_out;
    end
  end

  // ----------------------------------------
  // Timebase sampling
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tb1_cap_q <= 16'h0000;
      tb2_cap_q <= 16'h0000;
    end else if (fire && seq_sample) begin
      tb1_cap_q <= timebase_one_count;
      tb2_cap_q <= timebase_two_count;
    end
  end

  // ----------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------
  // Set wins over the read-clear so an event in the read cycle survives.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (i == STAT_SERVICE_BIT && svc_event && ctrl_q[CTRL_IEN_BIT]) begin
          status_q[i] <= 1'b1;
        end else if (i == STAT_OVERRUN_BIT && svc_wr && svc_q != SVC_NONE) begin
          status_q[i] <= 1'b1;
        end else if (reg_rd && reg_addr == ADDR_STATUS) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
      service_req <= 1'b0;
      service_prio <= 2'h0;
    end else begin
      irq <= |(status_q & mask_q);
      service_req <= (svc_q != SVC_NONE) && enabled && !fire;
      service_prio <= prio;
    end
  end

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: reg_rdata <= ctrl_q;
        ADDR_DELAY: reg_rdata <= delay_q;
        ADDR_REF_TIME: reg_rdata <= ref_time_q;
        ADDR_RATIO: reg_rdata <= ratio_q;
        ADDR_MATCH: reg_rdata <= match_q;
        ADDR_TB1: reg_rdata <= tb1_cap_q;
        ADDR_TB2: reg_rdata <= tb2_cap_q;
        ADDR_STATUS: reg_rdata <= status_q;
        ADDR_MASK: reg_rdata <= mask_q;
        ADDR_SERVICE: reg_rdata <= {offset_q[15:2], svc_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_run_toggle;
    @(posedge clk) disable iff (!reset_n)
      (state_q == ST_RUN && matched && enabled && !fire) |=> (pin_out != $past(pin_out));
  endproperty
  a_run_toggle: assert property (p_run_toggle) else $error("run match did not toggle");

  property p_next_match;
    @(posedge clk) disable iff (!reset_n)
      (state_q == ST_RUN && matched && !fire) |=> (match_q == $past(match_q) + $past(offset_q));
  endproperty
  a_next_match: assert property (p_next_match) else $error("next match drifted");

  property p_calc_delay;
    @(posedge clk) disable iff (!reset_n)
      ($rose(state_q == ST_CALC)) |-> (state_q == ST_CALC) [*2] ##1 (state_q == ST_RUN || fire);
  endproperty
  a_calc_delay: assert property (p_calc_delay) else $error("calc delay wrong");

  property p_offset;
    @(posedge clk) disable iff (!reset_n)
      (state_q == ST_IDLE && cont_q && link_in && enabled && !seq_sample && !fire)
        |=> (offset_q == $past(product[31:16]));
  endproperty
  a_offset: assert property (p_offset) else $error("offset not period times ratio");

  property p_high;
    @(posedge clk) disable iff (!reset_n)
      (fire && svc_q == SVC_PULSE && !seq_sample && edge_act == EDGE_HIGH) |=> pin_out;
  endproperty
  a_high: assert property (p_high) else $error("pin not driven high");

  property p_pulse_arm;
    @(posedge clk) disable iff (!reset_n)
      (fire && svc_q == SVC_PULSE && !seq_sample) |=> (state_q == ST_ARMED);
  endproperty
  a_pulse_arm: assert property (p_pulse_arm) else $error("pulse not armed");

  property p_sample;
    @(posedge clk) disable iff (!reset_n)
      (fire && seq_sample) |=> (tb1_cap_q == $past(timebase_one_count)) && !svc_q[0];
  endproperty
  a_sample: assert property (p_sample) else $error("timebase not sampled");

  property p_disabled;
    @(posedge clk) disable iff (!reset_n)
      (prio == PRIO_OFF && !svc_wr) |=> (!service_req && svc_q == $past(svc_q));
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled channel acted on request");

  property p_ien;
    @(posedge clk) disable iff (!reset_n)
      (svc_event && ctrl_q[CTRL_IEN_BIT]) |=> status_q[STAT_SERVICE_BIT];
  endproperty
  a_ien: assert property (p_ien) else $error("service flag lost");

  property p_now_match;
    @(posedge clk) disable iff (!reset_n)
      (fire && svc_q == SVC_PULSE && !seq_sample && ref_time_q == 16'h0000)
        |=> (match_q == $past(now) + $past(delay_q));
  endproperty
  a_now_match: assert property (p_now_match) else $error("pulse delay not from now");

  property p_ref_match;
    @(posedge clk) disable iff (!reset_n)
      (fire && svc_q == SVC_PULSE && !seq_sample && ref_time_q != 16'h0000)
        |=> (match_q == $past(ref_time_q) + $past(delay_q));
  endproperty
  a_ref_match: assert property (p_ref_match) else $error("edge not at ref plus delay");

  property p_armed_edge;
    @(posedge clk) disable iff (!reset_n)
      (state_q == ST_ARMED && matched && !fire && edge_act == EDGE_TOGGLE)
        |=> (pin_out != $past(pin_out));
  endproperty
  a_armed_edge: assert property (p_armed_edge) else $error("delayed edge missing");

  property p_prio_high;
    @(posedge clk) disable iff (!reset_n)
      (prio == PRIO_HIGH) |=> (service_prio == PRIO_HIGH);
  endproperty
  a_prio_high: assert property (p_prio_high) else $error("high priority not reported");

  property p_ien_off;
    @(posedge clk) disable iff (!reset_n)
      (!ctrl_q[CTRL_IEN_BIT] && !status_q[STAT_SERVICE_BIT]) |=> !status_q[STAT_SERVICE_BIT];
  endproperty
  a_ien_off: assert property (p_ien_off) else $error("service flag set while gated");

  property p_unused;
    @(posedge clk) disable iff (!reset_n)
      (fire && svc_q == SVC_UNUSED && state_q == ST_IDLE && !svc_wr)
        |=> ($stable(pin_out) && svc_q == SVC_NONE);
  endproperty
  a_unused: assert property (p_unused) else $error("unused service code acted on");

endmodule // output_compare_channel

// File: testbench/pin_load.sv
// Load model on the channel output pin, measuring level widths
`timescale 1ns/1ps
module pin_load (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Observed pin and timebase
  input wire logic pin,
  input wire logic [15:0] tb,
  // Measurements
  output logic [15:0] hi_w,
  output logic [15:0] lo_w,
  output logic [15:0] edge_tb
);
  logic pin_q;
  logic [15:0] run_q;

  // Only completed levels are reported, so a level still in progress never reads short
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
      run_q <= 16'h0001;
      hi_w <= 16'h0000;
      lo_w <= 16'h0000;
      edge_tb <= 16'h0000;
    end else if (pin !== pin_q) begin
      pin_q <= pin;
      run_q <= 16'h0001;
      edge_tb <= tb;
      if (pin_q) hi_w <= run_q;
      else lo_w <= run_q;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule // pin_load

// File: testbench/tb_top.sv
// Self-checking bench for the output compare channel
`timescale 1ns/1ps
module tb_top;
  import edge_sched_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] e;} row_t;
  logic clk, reset_n, reg_wr, reg_rd, link_in, service_grant;
  logic pin_out, service_req, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, tb1, tb2, rv, t, hi_w, lo_w, edge_tb;
  logic [1:0] service_prio;
  int num_errors, tests_run, cyc;
  row_t rows [5] = '{'{ADDR_DELAY, 16'h0040, 16'h0040}, '{ADDR_RATIO, 16'h8000, 16'h8000},
    '{ADDR_MASK, 16'h0001, 16'h0001}, '{ADDR_CTRL, 16'h0035, 16'h0035},
    '{4'hf, 16'h1234, 16'h0000}};

  // Second timebase moves with the first, so a joint sample has a known relation
  assign tb2 = tb1 ^ 16'h5a5a;

  output_compare_channel u_output_compare_channel (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timebase_one_count(tb1), .timebase_two_count(tb2), .link_in(link_in),
    .period_reference_value(16'h0040), .service_grant(service_grant),
    .pin_out(pin_out), .service_prio(service_prio), .service_req(service_req), .irq(irq));

  pin_load u_pin_load (
    .clk(clk), .reset_n(reset_n), .pin(pin_out), .tb(tb1),
    .hi_w(hi_w), .lo_w(lo_w), .edge_tb(edge_tb));

  // --------------------------------
  // Clock, timebase and timeout
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // A free-running count, so match times are always moving targets
  always @(posedge clk) begin
    tb1 <= tb1 + 16'h0001;
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      conclude();
    end
  end

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobe drops one edge later, so back-to-back calls never drive it twice per step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {reset_n, reg_wr, reg_rd, link_in, service_grant} = 5'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    tb1 = 16'h0000;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    service_grant <= 1'b1;
    #1 chk({pin_out, irq, service_req, service_prio}, 16'h0000);
    rd(ADDR_MASK, rv);
    chk(rv, MASK_RESET);
    rd(ADDR_CTRL, rv);
    chk(rv, CTRL_RESET);
    // Register rows, unmapped address last
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rv);
      chk(rv, rows[i].e);
    end
    // Every priority code reaches the scheduler
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, 16'(p << 4));
      cycles(2);
      chk({14'h0, service_prio}, 16'(p));
    end
    // Host pulse: immediate toggle, second toggle after the delay
    wr(ADDR_MASK, 16'h0003);
    wr(ADDR_DELAY, 16'h0014);
    wr(ADDR_CTRL, 16'h0073);
    wr(ADDR_SERVICE, 16'h0001);
    for (int i = 0; i < 200 && hi_w === 16'h0000; i++) cycles(1);
    chk(hi_w, 16'h0014);
    chk({15'h0, irq}, 16'h0001);
    rd(ADDR_STATUS, rv);
    chk(rv, 16'h0001);
    cycles(3);
    chk({15'h0, irq}, 16'h0000);
    // Edge at a delay from a host time, with the interrupt disabled
    t = tb1 + 16'h0064;
    wr(ADDR_REF_TIME, t);
    wr(ADDR_DELAY, 16'h000a);
    wr(ADDR_CTRL, 16'h0033);
    wr(ADDR_SERVICE, 16'h0001);
    for (int i = 0; i < 300 && edge_tb !== t + 16'h000b; i++) cycles(1);
    chk(edge_tb, t + 16'h000b);
    rd(ADDR_MATCH, rv);
    chk(rv, t + 16'h000a);
    chk({15'h0, irq}, 16'h0000);
    // Sequence 1x only samples the timebases; grant held off so the request pends
    @(posedge clk);
    service_grant <= 1'b0;
    wr(ADDR_CTRL, 16'h003b);
    wr(ADDR_SERVICE, 16'h0001);
    wr(ADDR_SERVICE, 16'h0001);
    cycles(2);
    chk({15'h0, service_req}, 16'h0001);
    chk({15'h0, irq}, 16'h0001);
    rd(ADDR_STATUS, rv);
    chk(rv, 16'h0002);
    @(posedge clk);
    service_grant <= 1'b1;
    cycles(4);
    chk({15'h0, pin_out}, 16'h0000);
    rd(ADDR_TB1, t);
    rd(ADDR_TB2, rv);
    chk(t ^ rv, 16'h5a5a);
    // Disabled channel keeps its request but never acts; the unused code is ignored
    wr(ADDR_CTRL, 16'h0003);
    wr(ADDR_SERVICE, 16'h0001);
    cycles(4);
    chk({pin_out, service_req}, 2'b00);
    rd(ADDR_SERVICE, rv);
    chk(rv, 16'h0001);
    // Withdraw the pending pulse before enabling, or it would fire at once
    wr(ADDR_SERVICE, 16'h0000);
    wr(ADDR_CTRL, 16'h0033);
    wr(ADDR_SERVICE, 16'h0002);
    cycles(4);
    chk({15'h0, pin_out}, 16'h0000);
    // Continuous wave: period 64 times ratio one half gives 32 per level
    wr(ADDR_RATIO, 16'h8000);
    wr(ADDR_SERVICE, 16'h0003);
    @(posedge clk);
    link_in <= 1'b1;
    @(posedge clk);
    link_in <= 1'b0;
    cycles(2);
    chk({15'h0, pin_out}, 16'h0000);
    cycles(300);
    chk(hi_w, 16'h0020);
    chk(lo_w, 16'h0020);
    rd(ADDR_SERVICE, rv);
    chk(rv, 16'h0020);
    conclude();
  end
endmodule // tb_top
